// ### hw/spi_enable_reset_control.sv
// Purpose: enable, disable, soft reset and fault gating of a serial unit
// Assumes: one system clock; link pins sampled through synchronisers
// Notes: word stream is 8 bits, msb first, mode 0
// Notes on behaviour
// - in slave mode a disable command is ignored; only soft reset stops
// - writing one to soft_reset_bit resets the unit
// - hold select on channel 0 with fault detection on blocks starts
// - setting fault_detect_disable lets held-select transfers start again
// - writes to tx_holding_reg while disabled are discarded
// - disable keeps tx_holding_empty; discarded write leaves it set
`timescale 1ns/1ps
`default_nettype none
module spi_enable_reset_control
	import spi_erc_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// control_reg strobes
	input wire logic i_enable_cmd,
	input wire logic i_disable_cmd,
	input wire logic i_soft_reset_bit,
	// mode_reg and select0_config writes
	input wire logic i_mode_wr,
	input wire logic i_master_mode,
	input wire logic i_fault_detect_disable,
	input wire logic i_cfg_wr,
	input wire logic i_hold_select_after_transfer,
	// tx_holding_reg write (cpu or peripheral_dma_channel)
	input wire logic i_tx_wr,
	input wire logic [WORD_W-1:0] i_tx_data,
	// rx read strobe
	input wire logic i_rx_rd,
	// link pins
	input wire logic i_sck,
	input wire logic i_sel_n,
	input wire logic i_mosi,
	input wire logic i_miso,
	output logic o_sck,
	output logic o_sel_n,
	output logic o_mosi,
	output logic o_miso,
	output logic o_miso_oe,
	// status
	output logic o_enabled,
	output logic o_tx_holding_empty,
	output logic o_rx_full,
	output logic [WORD_W-1:0] o_rx_data,
	output logic o_busy,
	output logic o_fault_detect_disable,
	output logic o_hold_select_after_transfer,
	output logic o_master_mode
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic sck_s, sel_n_s, mosi_s, miso_s;
	spi_erc_sync u_sck (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
		.i_async(i_sck), .o_sync(sck_s));
	spi_erc_sync u_sel (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
		.i_async(i_sel_n), .o_sync(sel_n_s));
	spi_erc_sync u_mosi (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
		.i_async(i_mosi), .o_sync(mosi_s));
	spi_erc_sync u_miso (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
		.i_async(i_miso), .o_sync(miso_s));

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic en_q, en_d, master_q, master_d, fdis_q, fdis_d, hold_q, hold_d;
	logic txe_q, txe_d, rxf_q, rxf_d;
	logic [WORD_W-1:0] hold_reg_q, hold_reg_d, sh_q, sh_d, rx_q, rx_d;
	logic [CNT_W-1:0] bit_q, bit_d, div_q, div_d;
	logic sck_q, sck_d, sckp_q, sel_q, sel_d, selp_q, mo_q, mo_d;
	xfer_e st_q, st_d;
	logic start_ok, link_rise, link_fall, sel_act, tick;

	// slave edges from sampled clock; master edges from divider
	assign tick = (div_q == DIV_LAST);
	assign link_rise = master_q ? (tick && !sck_q) : (sck_s && !sckp_q);
	assign link_fall = master_q ? (tick && sck_q) : (!sck_s && sckp_q);
	assign sel_act = master_q ? 1'b1 : (!sel_n_s && !selp_q);
	// held select plus live fault detection jams start
	assign start_ok = !(hold_q && !fdis_q);

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		en_d = en_q;
		master_d = master_q;
		fdis_d = fdis_q;
		hold_d = hold_q;
		txe_d = txe_q;
		rxf_d = rxf_q;
		hold_reg_d = hold_reg_q;
		sh_d = sh_q;
		rx_d = rx_q;
		bit_d = bit_q;
		div_d = tick ? '0 : div_q + 4'h1;
		sck_d = sck_q;
		sel_d = sel_q;
		mo_d = mo_q;
		st_d = st_q;
		if (i_mode_wr) begin
			master_d = i_master_mode;
			fdis_d = i_fault_detect_disable;
		end
		if (i_cfg_wr) hold_d = i_hold_select_after_transfer;
		if (i_enable_cmd) en_d = 1'b1;
		// slave ignores disable; txe untouched
		if (i_disable_cmd && master_q) en_d = 1'b0;
		// filtered write leaves empty flag set
		if (i_tx_wr && en_q) begin
			hold_reg_d = i_tx_data;
			txe_d = 1'b0;
		end
		if (i_rx_rd) rxf_d = 1'b0;
		// start sets the empty flag and that set wins over a same-cycle
		// write; software polls the flag before it writes the next word
		unique case (st_q)
			ST_IDLE: begin
				if (master_q && !hold_q) sel_d = 1'b1;
				if (en_q && !txe_q && start_ok &&
					(master_q || sel_act)) begin
					sh_d = hold_reg_q;
					txe_d = 1'b1;
					bit_d = '0;
					mo_d = hold_reg_q[WORD_W-1];
					sel_d = !master_q ? sel_q : 1'b0;
					div_d = '0;
					st_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (master_q && tick) sck_d = !sck_q;
				if (link_rise) sh_d = {sh_q[WORD_W-2:0],
					master_q ? miso_s : mosi_s};
				if (link_fall) begin
					if (bit_q == BIT_LAST) begin
						st_d = ST_DONE;
					end else begin
						bit_d = bit_q + 4'h1;
						mo_d = sh_q[WORD_W-1];
					end
				end
			end
			ST_DONE: begin
				rx_d = sh_q;
				rxf_d = 1'b1; // set wins over read clear
				if (master_q && !hold_q) sel_d = 1'b1;
				st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// registers; soft reset clears all but the previous pin samples and drops data
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		// previous pin samples for edge finding; left unreset since they
		// follow the synchronisers, which are reset themselves
		sckp_q <= sck_s;
		selp_q <= sel_n_s;
		if (!i_nrst || i_soft_reset_bit) begin
			en_q <= RST_ENABLE;
			master_q <= RST_MASTER;
			fdis_q <= RST_FAULT_DIS;
			hold_q <= RST_HOLD_SEL;
			txe_q <= RST_TX_EMPTY;
			rxf_q <= 1'b0;
			hold_reg_q <= '0;
			sh_q <= '0;
			rx_q <= '0;
			bit_q <= '0;
			div_q <= '0;
			sck_q <= 1'b0;
			sel_q <= 1'b1;
			mo_q <= 1'b0;
			st_q <= ST_IDLE;
		end else begin
			en_q <= en_d;
			master_q <= master_d;
			fdis_q <= fdis_d;
			hold_q <= hold_d;
			txe_q <= txe_d;
			rxf_q <= rxf_d;
			hold_reg_q <= hold_reg_d;
			sh_q <= sh_d;
			rx_q <= rx_d;
			bit_q <= bit_d;
			div_q <= div_d;
			sck_q <= sck_d;
			sel_q <= sel_d;
			mo_q <= mo_d;
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_sck = sck_q;
	assign o_sel_n = sel_q;
	assign o_mosi = mo_q;
	assign o_miso = mo_q;
	assign o_miso_oe = !master_q && !sel_n_s && en_q; // slave drives
	assign o_enabled = en_q;
	assign o_tx_holding_empty = txe_q;
	assign o_rx_full = rxf_q;
	assign o_rx_data = rx_q;
	assign o_busy = (st_q != ST_IDLE);
	assign o_fault_detect_disable = fdis_q;
	assign o_hold_select_after_transfer = hold_q;
	assign o_master_mode = master_q;
endmodule
`default_nettype wire

// ### hw/spi_erc_pkg.sv
// Purpose: shared constants for the serial peripheral enable/reset control
// Assumes: 25 MHz system clock, 8-bit words
// Notes: no register bus; control bits are plain ports
package spi_erc_pkg;
	localparam int WORD_W = 8;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] BIT_LAST = 4'h7;
	// reset values of control state
	localparam logic RST_ENABLE = 1'b0;
	localparam logic RST_MASTER = 1'b0;
	localparam logic RST_FAULT_DIS = 1'b0;
	localparam logic RST_HOLD_SEL = 1'b0;
	localparam logic RST_TX_EMPTY = 1'b1;
	// master link clock divider: one enable pulse every DIV_CYCLES
	localparam int SYS_CLK_HZ = 25000000;
	localparam int LINK_HZ = 3125000;
	localparam int DIV_CYCLES = SYS_CLK_HZ / LINK_HZ;
	localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(DIV_CYCLES - 1);
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} xfer_e;
endpackage

// ### hw/spi_erc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to i_sys_clk
// Notes: first stage read only by second
`timescale 1ns/1ps
`default_nettype none
module spi_erc_sync (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_q;
	logic sync_q;
	// ------------------------------------------------------------
	// two stages
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end
	assign o_sync = sync_q;
endmodule
`default_nettype wire

// ### verif/spi_erc_props.sv
// Purpose: port checks of the control block
// Assumes: sync active-low reset
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module spi_erc_props (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_enable_cmd,
	input wire logic i_disable_cmd,
	input wire logic i_soft_reset_bit,
	input wire logic i_mode_wr,
	input wire logic i_cfg_wr,
	input wire logic i_tx_wr,
	input wire logic o_enabled,
	input wire logic o_tx_holding_empty,
	input wire logic o_rx_full,
	input wire logic o_busy,
	input wire logic o_sel_n,
	input wire logic o_sck,
	input wire logic o_mosi,
	input wire logic o_master_mode,
	input wire logic o_fault_detect_disable,
	input wire logic o_hold_select_after_transfer
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	// no strobe that could change the outcome
	wire q = !(i_soft_reset_bit | i_disable_cmd | i_mode_wr | i_cfg_wr);
	wire hold = o_hold_select_after_transfer && !o_fault_detect_disable;
	sequence go_s;
		o_enabled && o_master_mode && i_tx_wr && !o_busy && q &&
		o_tx_holding_empty && !hold ##1 q;
	endsequence
	chk_start_walk: assert property (go_s |=> o_busy && !o_sel_n)
		else $error("no start");
	chk_first_bit: assert property ($rose(o_busy) && o_master_mode
		|=> (!o_sck && ($stable(o_mosi) || !o_busy))[*7])
		else $error("bit7 slip");
	chk_hold_block: assert property (hold |=> !$rose(o_busy))
		else $error("held start");
	chk_tx_drop: assert property (!o_enabled && i_tx_wr &&
		o_tx_holding_empty |=> o_tx_holding_empty) else $error("tx kept");
	chk_slave_hold: assert property (o_enabled && !o_master_mode &&
		i_disable_cmd && !i_soft_reset_bit |=> o_enabled)
		else $error("slave off");
	chk_empty_kept: assert property (o_enabled && hold &&
		i_disable_cmd && !i_soft_reset_bit && !o_tx_holding_empty
		|=> !o_tx_holding_empty) else $error("empty lost");
	chk_soft_off: assert property (i_soft_reset_bit |=> !o_enabled &&
		o_tx_holding_empty && !o_rx_full && o_sel_n) else $error("reset");
	chk_soft_fields: assert property (i_soft_reset_bit |=>
		!o_master_mode && !o_fault_detect_disable &&
		!o_hold_select_after_transfer && !o_busy) else $error("fields");
	chk_enable_on: assert property (i_enable_cmd && q |=> o_enabled)
		else $error("enable");
endmodule
bind spi_enable_reset_control spi_erc_props u_props (.*);
`default_nettype wire

// ### verif/spi_erc_partner.sv
// Purpose: serial slave facing the master link
// Assumes: mode 0, msb first
// Notes: replies i_reply, keeps heard word
`timescale 1ns/1ps
`default_nettype none
module spi_erc_partner (
	input wire logic i_sck, i_sel_n, i_mosi,
	input wire logic [7:0] i_reply,
	output logic o_miso,
	output logic [7:0] o_got = 8'h00
);
	logic [7:0] sh;
	// load on select, shift on fall, sample on rise
	always @(negedge i_sel_n) sh = i_reply;
	always @(negedge i_sck) if (!i_sel_n) sh = {sh[6:0], 1'b0};
	always @(posedge i_sck) if (!i_sel_n) o_got = {o_got[6:0], i_mosi};
	// released line never shows a held bit
	assign o_miso = i_sel_n ? ~o_got[0] : sh[7];
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Purpose: scenarios for the control block
// Assumes: 40 ns clock, 320 ns slave link clock
// Notes: strobes packed in st
`timescale 1ns/1ps
`default_nettype none
module testbench
	import spi_erc_pkg::*;
;
	logic clk = 0, nrst = 0, m = 0, fd = 0, hs = 0;
	logic sck = 0, sel_n = 1, mosi = 0, miso, osck, osel_n, omosi;
	logic en, txe, rxf, busy, smiso, soe;
	logic [6:0] st = 7'h00;
	logic [WORD_W-1:0] txd = 8'h00, got, rxd;
	int n_fail = 0, n_checks = 0;
	spi_enable_reset_control DUT (.i_sys_clk(clk), .i_nrst(nrst),
		.i_enable_cmd(st[0]), .i_disable_cmd(st[1]),
		.i_soft_reset_bit(st[2]), .i_mode_wr(st[3]), .i_master_mode(m),
		.i_fault_detect_disable(fd), .i_cfg_wr(st[4]),
		.i_hold_select_after_transfer(hs), .i_tx_wr(st[5]),
		.i_tx_data(txd), .i_rx_rd(st[6]), .i_sck(sck), .i_sel_n(sel_n),
		.i_mosi(mosi), .i_miso(miso), .o_sck(osck), .o_sel_n(osel_n),
		.o_mosi(omosi), .o_miso(smiso), .o_miso_oe(soe), .o_enabled(en),
		.o_tx_holding_empty(txe), .o_rx_full(rxf), .o_rx_data(rxd),
		.o_busy(busy), .o_fault_detect_disable(), .o_master_mode(),
		.o_hold_select_after_transfer());
	spi_erc_partner u_slave (.i_sck(osck), .i_sel_n(osel_n),
		.i_mosi(omosi), .i_reply(8'h96), .o_miso(miso), .o_got(got));
	initial forever #20 clk = ~clk;
	task tick; @(posedge clk); #1; endtask
	// strobe low again before the next call may raise it
	task pulse(input logic [6:0] v); st = v; tick; st = 7'h00; tick; endtask
	task chk(input logic ok, input string s);
		n_checks++;
		if (!ok) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, s);
		end
	endtask
	task wb(input logic v);
		for (int i = 0; i < 300 && busy !== v; i++) tick;
		chk(busy === v, "busy wait");
	endtask
	task cfg(input logic a, b, c); m = a; fd = b; hs = c; pulse(7'h18); endtask
	task frame(input logic [7:0] w);
		txd = w;
		pulse(7'h20);
		wb(1);
		wb(0);
		tick;
	endtask
	task t_master;
		cfg(1, 0, 0);
		pulse(7'h01);
		frame(8'h3c);
		chk(got === 8'h3c && rxd === 8'h96 && rxf === 1'b1, "word");
		pulse(7'h40);
		chk(rxf === 1'b0 && osel_n === 1'b1, "rx read");
		$display("master done");
	endtask
	task t_hold;
		cfg(1, 0, 1);
		txd = 8'h5a;
		pulse(7'h20);
		repeat (40) tick;
		chk(busy === 1'b0, "held start");
		cfg(1, 1, 1);
		wb(1);
		wb(0);
		chk(got === 8'h5a && osel_n === 1'b0, "held word");
		pulse(7'h04);
		chk(en === 1'b0 && osel_n === 1'b1, "soft reset");
		$display("hold done");
	endtask
	task t_off;
		// held select parks a word, so the flag is low when disabled
		cfg(1, 0, 1);
		pulse(7'h01);
		txd = 8'he7;
		pulse(7'h20);
		pulse(7'h02);
		chk(txe === 1'b0 && en === 1'b0, "empty kept");
		pulse(7'h04);
		cfg(1, 0, 0);
		pulse(7'h01);
		repeat (2) tick; // channel stopped two slots first
		pulse(7'h02);
		chk(txe === 1'b1 && en === 1'b0, "off");
		// channel writes on after disable; all lost
		for (int k = 0; k < 3; k++) begin
			txd = k[7:0];
			pulse(7'h20);
			chk(txe === 1'b1 && busy === 1'b0, "dropped");
		end
		chk(got === 8'h5a, "no frame");
		pulse(7'h01); // unit first, then channel
		chk(busy === 1'b0 && txe === 1'b1, "nothing queued");
		frame(8'hc3);
		chk(got === 8'hc3, "resumed");
		$display("off done");
	endtask
	task t_slave;
		logic [7:0] sent;
		cfg(0, 1, 0);
		pulse(7'h01);
		// slave starts only with a word in holding; stale rx flag cleared
		txd = 8'h69;
		pulse(7'h60);
		chk(rxf === 1'b0 && txe === 1'b0, "slave load");
		sel_n = 0;
		pulse(7'h02);
		chk(en === 1'b1 && soe === 1'b1, "slave off");
		sent = 8'h00;
		for (int b = 7; b >= 0; b--) begin
			mosi = b[0];
			#160 sck = 1;
			sent = {sent[6:0], smiso};
			#160 sck = 0;
		end
		sel_n = 1;
		repeat (6) tick;
		chk(rxf === 1'b1 && rxd === 8'haa, "slave word");
		chk(sent === 8'h69, "slave reply");
		pulse(7'h04);
		chk(en === 1'b0 && rxf === 1'b0 && txe === 1'b1, "stop");
		chk(soe === 1'b0, "miso off");
		$display("slave done");
	endtask
	task final_report;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (10) tick;
		nrst = 1;
		t_master;
		t_hold;
		t_off;
		t_slave;
		final_report;
	end
	// cut a hang well past the expected run
	initial begin
		#200000;
		n_fail++;
		final_report;
	end
endmodule
`default_nettype wire
